// ===== rtl/dao_defs.svh
// constants for the dual converter output control block
`ifndef DAO_DEFS_SVH
`define DAO_DEFS_SVH

// ----------------------------------------------------------------
// result word and pipeline layout
// ----------------------------------------------------------------
`define DAO_WORD_W 14
`define DAO_MSB 13
`define DAO_LVL_W 16
`define DAO_LVL_SIGN 15
`define DAO_CODE_MAX 16'h3FFF
`define DAO_CODE_MAX_W 14'h3FFF
`define DAO_CODE_MIN_W 14'h0000
`define DAO_SLICE 2
`define DAO_LAST_SLICE 4
`define DAO_FRONT_STAGES 5
`define DAO_ALIGN 3
`define DAO_MSB_MASK 14'h2000

// ----------------------------------------------------------------
// four-level mode input codes
// ----------------------------------------------------------------
`define DAO_MODE_GND 2'h0
`define DAO_MODE_THIRD 2'h1
`define DAO_MODE_TWO_THIRD 2'h2
`define DAO_MODE_SUPPLY 2'h3

// ----------------------------------------------------------------
// synchronised pin vector layout
// ----------------------------------------------------------------
`define DAO_PIN_W 9
`define DAO_PIN_MODE_LO 0
`define DAO_PIN_MODE_HI 1
`define DAO_PIN_CLK_A 2
`define DAO_PIN_CLK_B 3
`define DAO_PIN_PD_A 4
`define DAO_PIN_PD_B 5
`define DAO_PIN_DEN_A 6
`define DAO_PIN_DEN_B 7
`define DAO_PIN_SWAP 8

// ----------------------------------------------------------------
// period measurement for the duty-cycle stabilizer
// ----------------------------------------------------------------
`define DAO_CNT_W 8
`define DAO_CNT_ONE 8'h01
`define DAO_CNT_MAX 8'hFF

`endif

// ===== rtl/dao_pkg.sv
// types shared by the dual converter output control block
`include "dao_defs.svh"

package dao_pkg;

    // one channel result: range flag beside the result word
    typedef struct packed {
        logic range;
        logic [`DAO_WORD_W-1:0] word;
    } dao_chan_t;

    // one pipeline stage: resolved bits so far and remaining residue
    typedef struct packed {
        logic ovr;
        logic [`DAO_WORD_W-1:0] bits;
        logic [`DAO_WORD_W-1:0] res;
    } dao_stage_t;

    // format and stabilizer decoded from the mode input
    typedef struct packed {
        logic twos;
        logic stab;
    } dao_mode_t;

    // power and drive state of one channel
    typedef enum logic [1:0] {
        DAO_RUN_DRIVE,
        DAO_RUN_QUIET,
        DAO_NAP,
        DAO_SLEEP
    } dao_power_t;

endpackage : dao_pkg

// ===== rtl/dao_pipe.sv
// six-stage conversion pipeline of one channel
`timescale 1ns/1ps
`include "dao_defs.svh"

module dao_pipe
    import dao_pkg::*;
#(
    parameter int ALIGN_DEPTH = `DAO_ALIGN
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // sample clock phases
    input wire logic track,
    input wire logic rise_en,
    input wire logic fall_en,
    // power control
    input wire logic run,
    input wire logic flush,
    // sampled input level, signed
    input wire logic [`DAO_LVL_W-1:0] level,
    // merged result
    output dao_chan_t result
);

    // ----------------------------------------------------------------
    // stage arithmetic
    // ----------------------------------------------------------------

    // front stage: clip to the code range and flag over or under range
    function automatic dao_stage_t stage_load(input logic [`DAO_LVL_W-1:0] lvl);
        dao_stage_t s;
        s.bits = '0;
        if (lvl[`DAO_LVL_SIGN])
        begin
            s.ovr = 1'b1;
            s.res = `DAO_CODE_MIN_W;
        end
        else if (lvl > `DAO_CODE_MAX)
        begin
            s.ovr = 1'b1;
            s.res = `DAO_CODE_MAX_W;
        end
        else
        begin
            s.ovr = 1'b0;
            s.res = lvl[`DAO_MSB:0];
        end
        return s;
    endfunction : stage_load

    // resolve one slice and pass the amplified residue on
    function automatic dao_stage_t stage_step(input dao_stage_t s);
        dao_stage_t n;
        n.ovr = s.ovr;
        n.bits = {s.bits[`DAO_MSB-`DAO_SLICE:0], s.res[`DAO_MSB -: `DAO_SLICE]};
        n.res = {s.res[`DAO_MSB-`DAO_SLICE:0], {`DAO_SLICE{1'b0}}};
        return n;
    endfunction : stage_step

    // last stage evaluates the residue and merges all partial results
    function automatic dao_chan_t stage_merge(input dao_stage_t s);
        dao_chan_t c;
        c.range = s.ovr;
        c.word = {s.bits[`DAO_MSB-`DAO_LAST_SLICE:0], s.res[`DAO_MSB -: `DAO_LAST_SLICE]};
        return c;
    endfunction : stage_merge

    logic [`DAO_LVL_W-1:0] hold_q, hold_d;
    dao_stage_t st_q [`DAO_FRONT_STAGES];
    dao_stage_t st_d [`DAO_FRONT_STAGES];
    dao_chan_t al_q [ALIGN_DEPTH];
    dao_chan_t al_d [ALIGN_DEPTH];
    dao_chan_t out_q, out_d;

    // ----------------------------------------------------------------
    // pipeline next state
    // ----------------------------------------------------------------

    // stages alternate edges; result leaves six sample cycles after hold
    always_comb
    begin
        hold_d = track ? level : hold_q;
        st_d = st_q;
        al_d = al_q;
        out_d = out_q;
        if (flush)
        begin
            for (int i = 0; i < `DAO_FRONT_STAGES; i++)
                st_d[i] = '0;
            for (int i = 0; i < ALIGN_DEPTH; i++)
                al_d[i] = '0;
            out_d = '0;
        end
        else if (run)
        begin
            // even on fall, odd on rise
            if (fall_en)
                st_d[0] = stage_step(stage_load(hold_q));
            for (int i = 1; i < `DAO_FRONT_STAGES; i++)
            begin
                if ((i % 2 == 0) ? fall_en : rise_en)
                    st_d[i] = stage_step(st_q[i-1]);
            end
            if (rise_en)
            begin
                al_d[0] = stage_merge(st_q[`DAO_FRONT_STAGES-1]);
                for (int i = 1; i < ALIGN_DEPTH; i++)
                    al_d[i] = al_q[i-1];
                out_d = al_q[ALIGN_DEPTH-1];
            end
        end
    end

    // pipeline registers
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            hold_q <= '0;
            for (int i = 0; i < `DAO_FRONT_STAGES; i++)
                st_q[i] <= '0;
            for (int i = 0; i < ALIGN_DEPTH; i++)
                al_q[i] <= '0;
            out_q <= '0;
        end
        else
        begin
            hold_q <= hold_d;
            st_q <= st_d;
            al_q <= al_d;
            out_q <= out_d;
        end
    end

    assign result = out_q;

endmodule : dao_pipe

// ===== rtl/dao_top.sv
// dual converter output control: sample clocks, power modes, format, bus swap
`timescale 1ns/1ps
`include "dao_defs.svh"

module dao_top
    import dao_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // sample clock pins
    input wire logic sample_clock_a,
    input wire logic sample_clock_b,
    // sampled analog levels, signed, in code units
    input wire logic [`DAO_LVL_W-1:0] level_a,
    input wire logic [`DAO_LVL_W-1:0] level_b,
    // mode pins
    input wire logic output_swap_select,
    input wire logic power_down_select_a,
    input wire logic power_down_select_b,
    input wire logic drive_enable_n_a,
    input wire logic drive_enable_n_b,
    input wire logic [1:0] mode_level,
    // bus A
    output logic [`DAO_WORD_W-1:0] bus_a_bits,
    output logic range_flag_a,
    output logic bus_a_oe_n,
    // bus B
    output logic [`DAO_WORD_W-1:0] bus_b_bits,
    output logic range_flag_b,
    output logic bus_b_oe_n
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------

    // four-level mode input to format and stabilizer
    function automatic dao_mode_t mode_decode(input logic [1:0] lvl);
        dao_mode_t m;
        unique case (lvl)
            `DAO_MODE_GND: m = '{twos: 1'b0, stab: 1'b0};
            `DAO_MODE_THIRD: m = '{twos: 1'b0, stab: 1'b1};
            `DAO_MODE_TWO_THIRD: m = '{twos: 1'b1, stab: 1'b1};
            `DAO_MODE_SUPPLY: m = '{twos: 1'b1, stab: 1'b0};
        endcase
        return m;
    endfunction : mode_decode

    // power-down and drive enable pins to channel state
    function automatic dao_power_t power_decode(input logic pd, input logic den_n);
        dao_power_t p;
        unique case ({pd, den_n})
            2'h0: p = DAO_RUN_DRIVE;
            2'h1: p = DAO_RUN_QUIET;
            2'h2: p = DAO_NAP;
            2'h3: p = DAO_SLEEP;
        endcase
        return p;
    endfunction : power_decode

    // offset binary to two's complement flips the top bit
    function automatic dao_chan_t format_word(input dao_chan_t c, input logic twos);
        dao_chan_t f;
        f.range = c.range;
        f.word = twos ? (c.word ^ `DAO_MSB_MASK) : c.word;
        return f;
    endfunction : format_word

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------

    logic [`DAO_PIN_W-1:0] pin_raw;
    logic [`DAO_PIN_W-1:0] sync1_q, sync2_q;

    // every pin passes two flops before use
    assign pin_raw = {output_swap_select, drive_enable_n_b, drive_enable_n_a,
                      power_down_select_b, power_down_select_a,
                      sample_clock_b, sample_clock_a, mode_level};

    // synchroniser flops
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    // ----------------------------------------------------------------
    // sample clock edges and duty-cycle stabilizer
    // ----------------------------------------------------------------

    dao_mode_t mode;
    logic [1:0] clk_lvl;
    logic [1:0] rise, fall, track;
    logic [1:0] prev_q, prev_d;
    logic [1:0] phase_q, phase_d;
    logic [`DAO_CNT_W-1:0] cnt_q [2];
    logic [`DAO_CNT_W-1:0] cnt_d [2];
    logic [`DAO_CNT_W-1:0] per_q [2];
    logic [`DAO_CNT_W-1:0] per_d [2];

    assign mode = mode_decode(sync2_q[`DAO_PIN_MODE_HI:`DAO_PIN_MODE_LO]);
    assign clk_lvl = {sync2_q[`DAO_PIN_CLK_B], sync2_q[`DAO_PIN_CLK_A]};

    // edges per channel; stabilizer rebuilds the fall at half period
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            rise[c] = clk_lvl[c] & ~prev_q[c];
            if (mode.stab)
            begin
                fall[c] = phase_q[c] && (per_q[c] != '0) && (cnt_q[c] == (per_q[c] >> 1));
                track[c] = ~phase_q[c];
            end
            else
            begin
                fall[c] = ~clk_lvl[c] & prev_q[c];
                track[c] = ~clk_lvl[c];
            end
            prev_d[c] = clk_lvl[c];
            phase_d[c] = rise[c] ? 1'b1 : (fall[c] ? 1'b0 : phase_q[c]);
            per_d[c] = rise[c] ? cnt_q[c] : per_q[c];
            if (rise[c])
                cnt_d[c] = `DAO_CNT_ONE;
            else if (cnt_q[c] != `DAO_CNT_MAX)
                cnt_d[c] = cnt_q[c] + `DAO_CNT_ONE;
            else
                cnt_d[c] = cnt_q[c];
        end
    end

    // edge and period registers
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            prev_q <= '0;
            phase_q <= '0;
            cnt_q <= '{default: '0};
            per_q <= '{default: '0};
        end
        else
        begin
            prev_q <= prev_d;
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            per_q <= per_d;
        end
    end

    // ----------------------------------------------------------------
    // power modes and conversion pipelines
    // ----------------------------------------------------------------

    dao_power_t pwr [2];
    logic [1:0] run, flush, drive;
    dao_chan_t res [2];
    logic [`DAO_LVL_W-1:0] level [2];

    assign pwr[0] = power_decode(sync2_q[`DAO_PIN_PD_A], sync2_q[`DAO_PIN_DEN_A]);
    assign pwr[1] = power_decode(sync2_q[`DAO_PIN_PD_B], sync2_q[`DAO_PIN_DEN_B]);
    assign level[0] = level_a;
    assign level[1] = level_b;

    // run, nap keeps contents, sleep clears the pipeline
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            unique case (pwr[c])
                DAO_RUN_DRIVE: {run[c], flush[c], drive[c]} = 3'h5;
                DAO_RUN_QUIET: {run[c], flush[c], drive[c]} = 3'h4;
                DAO_NAP: {run[c], flush[c], drive[c]} = 3'h0;
                DAO_SLEEP: {run[c], flush[c], drive[c]} = 3'h2;
            endcase
        end
    end

    // one pipeline per channel
    for (genvar c = 0; c < 2; c++)
    begin : g_chan
        dao_pipe #(
            .ALIGN_DEPTH(`DAO_ALIGN)
        ) u_pipe (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .track(track[c]),
            .rise_en(rise[c]),
            .fall_en(fall[c]),
            .run(run[c]),
            .flush(flush[c]),
            .level(level[c]),
            .result(res[c])
        );
    end

    // ----------------------------------------------------------------
    // output swap and drivers
    // ----------------------------------------------------------------

    dao_chan_t src_a, src_b;
    dao_chan_t out_a_q, out_a_d, out_b_q, out_b_d;
    logic oe_a_n_q, oe_a_n_d, oe_b_n_q, oe_b_n_d;

    // route channels to buses and apply format
    always_comb
    begin
        src_a = sync2_q[`DAO_PIN_SWAP] ? res[0] : res[1];
        src_b = sync2_q[`DAO_PIN_SWAP] ? res[1] : res[0];
        out_a_d = drive[0] ? format_word(src_a, mode.twos) : '0;
        out_b_d = drive[1] ? format_word(src_b, mode.twos) : '0;
        oe_a_n_d = ~drive[0];
        oe_b_n_d = ~drive[1];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            out_a_q <= '0;
            out_b_q <= '0;
            oe_a_n_q <= 1'b1;
            oe_b_n_q <= 1'b1;
        end
        else
        begin
            out_a_q <= out_a_d;
            out_b_q <= out_b_d;
            oe_a_n_q <= oe_a_n_d;
            oe_b_n_q <= oe_b_n_d;
        end
    end

    assign bus_a_bits = out_a_q.word;
    assign range_flag_a = out_a_q.range;
    assign bus_a_oe_n = oe_a_n_q;
    assign bus_b_bits = out_b_q.word;
    assign range_flag_b = out_b_q.range;
    assign bus_b_oe_n = oe_b_n_q;

endmodule : dao_top

// ===== sim/dao_top_checker.sv
// port assertions for the dual converter output control block
`timescale 1ns/1ps
`include "dao_defs.svh"

module dao_top_checker
    import dao_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // pins
    input wire logic sample_clock_a,
    input wire logic sample_clock_b,
    input wire logic output_swap_select,
    input wire logic power_down_select_a,
    input wire logic power_down_select_b,
    input wire logic drive_enable_n_a,
    input wire logic drive_enable_n_b,
    input wire logic [1:0] mode_level,
    // buses
    input wire logic [`DAO_WORD_W-1:0] bus_a_bits,
    input wire logic range_flag_a,
    input wire logic bus_a_oe_n,
    input wire logic [`DAO_WORD_W-1:0] bus_b_bits,
    input wire logic range_flag_b,
    input wire logic bus_b_oe_n
);
    logic [4:0] pins;
    logic [4:0] pin_q;
    logic [1:0] mode_q;
    logic [1:0] ck_q;
    logic [7:0] pin_age_q, pin_age_d, mode_age_q, mode_age_d;
    logic [7:0] clk_age_q, clk_age_d, rise_age_q, rise_age_d;

    // saturating count of cycles since an event
    function automatic logic [7:0] age(input logic hit, input logic [7:0] a);
        return hit ? 8'h00 : ((a == 8'hFF) ? a : a + 8'h01);
    endfunction : age

    // next values of the quiet counters
    always_comb
    begin
        pins = {output_swap_select, power_down_select_a, power_down_select_b,
                drive_enable_n_a, drive_enable_n_b};
        pin_age_d = age(pins != pin_q, pin_age_q);
        mode_age_d = age(mode_level != mode_q, mode_age_q);
        clk_age_d = age({sample_clock_a, sample_clock_b} != ck_q, clk_age_q);
        rise_age_d = age(|({sample_clock_a, sample_clock_b} & ~ck_q), rise_age_q);
    end

    // register counters and previous pin levels
    always_ff @(posedge clk_sys)
    begin
        pin_q <= pins;
        mode_q <= mode_level;
        ck_q <= {sample_clock_a, sample_clock_b};
        pin_age_q <= rstn ? pin_age_d : 8'h00;
        mode_age_q <= rstn ? mode_age_d : 8'h00;
        clk_age_q <= rstn ? clk_age_d : 8'h00;
        rise_age_q <= rstn ? rise_age_d : 8'h00;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    a_release_bus_a: assert property (
        (power_down_select_a || drive_enable_n_a)[*4] |-> bus_a_oe_n)
        else $error("bus a driven while released");
    a_release_bus_b: assert property (
        (power_down_select_b || drive_enable_n_b)[*4] |-> bus_b_oe_n)
        else $error("bus b driven while released");
    a_drive_bus_a: assert property (
        (!power_down_select_a && !drive_enable_n_a)[*4] |-> !bus_a_oe_n)
        else $error("bus a not driven in normal mode");
    a_drive_bus_b: assert property (
        (!power_down_select_b && !drive_enable_n_b)[*4] |-> !bus_b_oe_n)
        else $error("bus b not driven in normal mode");
    a_released_zero: assert property (
        (bus_a_oe_n |-> {range_flag_a, bus_a_bits} == 15'h0000)
        and (bus_b_oe_n |-> {range_flag_b, bus_b_bits} == 15'h0000))
        else $error("released bus not zero");
    a_format_msb_flip: assert property (
        ($changed(mode_level[1]) && !bus_a_oe_n ##1 $stable(mode_level[1])[*3])
        ##0 (pin_age_q > 8'h0A && clk_age_q > 8'h0A)
        |-> {range_flag_a, bus_a_bits} == ($past({range_flag_a, bus_a_bits}, 3) ^ 15'h2000))
        else $error("format change did not flip only the top bit");
    a_swap_exchange: assert property (
        ($changed(output_swap_select) && !bus_a_oe_n && !bus_b_oe_n
        ##1 $stable(output_swap_select)[*3])
        ##0 (mode_age_q > 8'h0A && clk_age_q > 8'h0A && !bus_a_oe_n && !bus_b_oe_n)
        |-> bus_a_bits == $past(bus_b_bits, 3) && range_flag_a == $past(range_flag_b, 3))
        else $error("swap select did not exchange the buses");
    a_word_after_rise: assert property (
        ($changed(bus_a_bits) && !bus_a_oe_n && !$past(bus_a_oe_n)
        && pin_age_q > 8'h05 && mode_age_q > 8'h05)
        |-> rise_age_q inside {[8'h02:8'h05]})
        else $error("bus a word changed away from a sample rise");
    a_word_hold: assert property (
        (pin_age_q > 8'h06 && mode_age_q > 8'h06 && clk_age_q > 8'h06)
        |-> $stable({range_flag_a, bus_a_bits}) && $stable({range_flag_b, bus_b_bits}))
        else $error("bus changed with all clocks and pins quiet");

    // main scenarios
    c_nap: cover property (power_down_select_a && !drive_enable_n_a && bus_a_oe_n);
    c_swap: cover property ($changed(output_swap_select) && clk_age_q > 8'h0A);
    c_word: cover property ($changed(bus_a_bits) && !bus_a_oe_n);
endmodule : dao_top_checker

bind dao_top dao_top_checker u_chk (.clk_sys, .rstn, .sample_clock_a, .sample_clock_b,
    .output_swap_select, .power_down_select_a, .power_down_select_b, .drive_enable_n_a,
    .drive_enable_n_b, .mode_level, .bus_a_bits, .range_flag_a, .bus_a_oe_n, .bus_b_bits,
    .range_flag_b, .bus_b_oe_n);

// ===== sim/dao_capture.sv
// capture logic model that registers both output buses
`timescale 1ns/1ps
`include "dao_defs.svh"

module dao_capture
    import dao_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // bus pins
    input wire logic [`DAO_WORD_W-1:0] bus_a_bits,
    input wire logic range_flag_a,
    input wire logic bus_a_oe_n,
    input wire logic [`DAO_WORD_W-1:0] bus_b_bits,
    input wire logic range_flag_b,
    input wire logic bus_b_oe_n,
    // captured words
    output dao_chan_t cap_a,
    output dao_chan_t cap_b
);
    dao_chan_t wire_a, wire_b;

    // a released bus floats: it shows a pattern that changes every cycle
    always_comb
    begin
        wire_a = bus_a_oe_n ? ~cap_a : {range_flag_a, bus_a_bits};
        wire_b = bus_b_oe_n ? ~cap_b : {range_flag_b, bus_b_bits};
    end

    // register one word per clock
    always_ff @(posedge clk_sys)
    begin
        cap_a <= wire_a;
        cap_b <= wire_b;
    end
endmodule : dao_capture

// ===== sim/dao_top_tb_top.sv
// self-checking bench for the dual converter output control block
`timescale 1ns/1ps
`include "dao_defs.svh"

module dao_top_tb_top
    import dao_pkg::*;
;
    typedef struct packed {
        logic [1:0] mode;
        logic swap;
        logic [15:0] la;
        logic [15:0] lb;
        dao_chan_t ea;
        dao_chan_t eb;
    } dao_row_t;

    logic clk_sys = 1'b0;
    logic rstn, sck_a, sck_b, swap, pd_a, pd_b, den_a, den_b, tie;
    logic [1:0] mode;
    logic [15:0] lvl_a, lvl_b;
    logic [13:0] bits_a, bits_b;
    logic flag_a, flag_b, oe_a, oe_b;
    dao_chan_t cap_a, cap_b;
    int bad_count = 0;
    int num_checks = 0;
    dao_row_t rows [4] = '{
        '{2'h0, 1'b1, 16'h1234, 16'h0001, 15'h1234, 15'h0001},
        '{2'h1, 1'b0, 16'h2ABC, 16'hFFFB, 15'h4000, 15'h2ABC},
        '{2'h2, 1'b1, 16'h4000, 16'h3FFF, 15'h5FFF, 15'h1FFF},
        '{2'h3, 1'b0, 16'h0000, 16'h2000, 15'h0000, 15'h2000}};

    // design and capture model
    dao_top uut (.clk_sys(clk_sys), .rstn(rstn), .sample_clock_a(sck_a),
        .sample_clock_b(sck_b), .level_a(lvl_a), .level_b(lvl_b),
        .output_swap_select(swap), .power_down_select_a(pd_a), .power_down_select_b(pd_b),
        .drive_enable_n_a(den_a), .drive_enable_n_b(den_b), .mode_level(mode),
        .bus_a_bits(bits_a), .range_flag_a(flag_a), .bus_a_oe_n(oe_a),
        .bus_b_bits(bits_b), .range_flag_b(flag_b), .bus_b_oe_n(oe_b));
    dao_capture far (.clk_sys(clk_sys), .bus_a_bits(bits_a), .range_flag_a(flag_a),
        .bus_a_oe_n(oe_a), .bus_b_bits(bits_b), .range_flag_b(flag_b), .bus_b_oe_n(oe_b),
        .cap_a(cap_a), .cap_b(cap_b));

    // system clock
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    // wait n edges, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    // drive both sample clocks, and swap select when tied to them
    task automatic set_ck(input logic v);
        sck_a = v;
        sck_b = v;
        if (tie)
            swap = v;
    endtask : set_ck

    // n sample periods, four cycles low then four high
    task automatic pulse(input int n);
        repeat (n)
        begin
            set_ck(1'b0);
            tick(4);
            set_ck(1'b1);
            tick(4);
        end
    endtask : pulse

    // compare one channel word
    task automatic chk_chan(input string what, input dao_chan_t exp, input dao_chan_t got);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_chan

    // compare one flag
    task automatic chk_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    // counts and verdict
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    // main sequence
    initial
    begin
        {rstn, sck_a, sck_b, pd_a, pd_b, den_a, den_b, tie} = 8'h00;
        swap = 1'b1;
        mode = 2'h0;
        lvl_a = 16'h0000;
        lvl_b = 16'h0000;
        tick(8);
        chk_bit("oe a in reset", 1'b1, oe_a);
        chk_chan("bus b in reset", 15'h0000, {flag_b, bits_b});
        rstn = 1'b1;
        tick(4);
        foreach (rows[i])
        begin
            mode = rows[i].mode;
            swap = rows[i].swap;
            lvl_a = rows[i].la;
            lvl_b = rows[i].lb;
            pulse(10);
            tick(4);
            chk_chan("row bus a", rows[i].ea, cap_a);
            chk_chan("row bus b", rows[i].eb, cap_b);
        end
        set_ck(1'b0);
        tick(12);
        mode = 2'h0;
        // long enough that the swap assertion sees a settled mode pin
        tick(9);
        chk_chan("format bus a", 15'h2000, cap_a);
        swap = 1'b1;
        tick(6);
        chk_chan("swap bus a", 15'h0000, cap_a);
        chk_chan("swap bus b", 15'h2000, cap_b);
        lvl_a = 16'h0155;
        pulse(6);
        set_ck(1'b0);
        tick(2);
        chk_chan("latency old word", 15'h0000, cap_a);
        tick(2);
        set_ck(1'b1);
        tick(6);
        chk_chan("latency new word", 15'h0155, cap_a);
        for (int k = 0; k < 4; k++)
        begin
            {pd_a, den_a} = k[1:0];
            {pd_b, den_b} = k[1:0];
            tick(4);
            chk_bit("oe a mode", k != 0, oe_a);
            chk_bit("oe b mode", k != 0, oe_b);
        end
        {pd_a, pd_b, den_b} = 3'h0;
        lvl_a = 16'h3ABC;
        pulse(8);
        den_a = 1'b0;
        tick(5);
        chk_chan("quiet conversion", 15'h3ABC, cap_a);
        lvl_a = 16'h0AAA;
        lvl_b = 16'h0555;
        // swap select and both clocks from one signal
        tie = 1'b1;
        pulse(10);
        set_ck(1'b0);
        tick(2);
        chk_chan("mux high bus a", 15'h0AAA, cap_a);
        tick(4);
        chk_chan("mux low bus a", 15'h0555, cap_a);
        chk_chan("mux low bus b", 15'h0AAA, cap_b);
        // mid-run reset releases both buses and clears the words
        rstn = 1'b0;
        tick(2);
        chk_bit("oe b in mid reset", 1'b1, oe_b);
        chk_chan("bus a in mid reset", 15'h0000, {flag_a, bits_a});
        summarize();
    end

    // hang guard
    initial
    begin
        #200000;
        bad_count++;
        $display("MISMATCH run time expected finish seen timeout");
        summarize();
    end
endmodule : dao_top_tb_top
